// [hw/tat_pkg.sv]
// constants and types shared by the interval timer blocks
package tat_pkg;
  // register word offsets on the peripheral register port
  localparam logic [15:0] CTRL_OFF   = 16'h2000;
  localparam logic [15:0] COUNT_OFF  = 16'h2010;
  localparam logic [15:0] PERIOD_OFF = 16'h2020;

  // alias operation taken from address bits 3:2
  typedef enum logic [1:0] {
    ALIAS_WRITE = 2'h0,
    ALIAS_CLR   = 2'h1,
    ALIAS_SET   = 2'h2,
    ALIAS_INV   = 2'h3
  } tat_alias_type;

  // control field positions
  localparam int unsigned ON_BIT    = 15;
  localparam int unsigned STOP_IN_IDLE_BIT  = 13;
  localparam int unsigned WDIS_BIT  = 12;
  localparam int unsigned WIP_BIT   = 11;
  localparam int unsigned ECS_LSB   = 8;
  localparam int unsigned GATE_BIT  = 7;
  localparam int unsigned PS_LSB    = 4;
  localparam int unsigned SYNC_BIT  = 2;
  localparam int unsigned CS_BIT    = 1;

  // writable and readable control bits
  localparam logic [31:0] CTRL_WMASK = 32'h0000B3B6;
  localparam logic [31:0] CTRL_RMASK = 32'h0000BBB6;

  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h00000000;
  localparam logic [31:0] COUNT_RST  = 32'h00000000;
  localparam logic [31:0] PERIOD_RST = 32'h0000FFFF;

  // external source codes
  localparam logic [1:0] ECS_SECONDARY_OSCILLATOR = 2'h0;
  localparam logic [1:0] ECS_PIN  = 2'h1;
  localparam logic [1:0] ECS_LOW_POWER_RC_CLOCK = 2'h2;

  // least spacing of count writes, peripheral bus cycles
  localparam int unsigned COUNT_WR_SPACING = 4;
endpackage

// [hw/tat_prescaler.sv]
// input clock prescaler: divide tick stream by 1, 8, 64 or 256
`timescale 1ns/1ns
`default_nettype none
module tat_prescaler #(
  parameter int unsigned CNT_W = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // control
  input  wire logic             clear,
  input  wire logic [1:0]       sel,
  // ticks
  input  wire logic             tick_in,
  output logic                  tick_out
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;

  always_comb begin
    unique case (sel)
      2'h0: last = CNT_W'(0);
      2'h1: last = CNT_W'(7);
      2'h2: last = CNT_W'(63);
      2'h3: last = CNT_W'(255);
    endcase
  end

  assign tick_out = tick_in && (cnt_q == last);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (clear) begin
        cnt_q <= '0;
      end else if (tick_in) begin
        cnt_q <= (cnt_q == last) ? '0 : cnt_q + CNT_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// [hw/tat_interval_timer.sv]
// interval timer with control, count and period registers
// Behaviour
// - each register also answers at +0x4 clear, +0x8 set, +0xC invert.
// - with bit 13 set the timer stops while the device is idle.
// - with bit 12 set count writes are ignored while one is pending.
// - bit 11 reads one while an async count write is pending, else zero.
// - bits 9-8 pick oscillator, clock pin or rc clock; 11 is reserved.
// - bit 7 gates internal counting by the pin and is ignored externally.
// - the prescale field divides the input by 1, 8, 64 or 256.
// - with external source, bit 2 selects synchronized counting.
// - bit 1 selects the external source, clear selects the bus clock.
// - unimplemented control bits ignore writes and read zero.
// - with bit 1 set and bit 2 clear the timer keeps running in sleep and can request a wake-up.
// - each period event drives a capacitive sense trigger output.
`timescale 1ns/1ns
`default_nettype none
module tat_interval_timer #(
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // register port
  input  wire logic [15:0]      reg_addr,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [31:0]      reg_wdata,
  output logic      [31:0]      reg_rdata,
  // power state
  input  wire logic             idle_mode,
  input  wire logic             sleep_mode,
  // external clock sources
  input  wire logic             secondary_oscillator,
  input  wire logic             ext_clock_pin,
  input  wire logic             low_power_rc_clock,
  // events
  output logic                  timer_event,
  output logic                  capacitive_sense_trigger,
  output logic                  wake_request
);
  logic [31:0]      ctrl_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] period_q;
  logic             pend_q;
  logic [CNT_W-1:0] pend_val_q;
  logic [2:0]       sync_q [3];
  logic [2:0]       lvl_q;
  logic [2:0]       rise;
  logic             ext_edge;
  logic             src_tick;
  logic             run;
  logic             tick;
  logic             async_mode;
  logic             cnt_wr;
  logic             cnt_take;
  logic [CNT_W-1:0] cnt_new;
  logic [CNT_W-1:0] cnt_base;
  logic             wrap;
  tat_pkg::tat_alias_type op;

  function automatic logic [31:0] alias_apply(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input tat_pkg::tat_alias_type o);
    unique case (o)
      tat_pkg::ALIAS_WRITE: alias_apply = wd;
      tat_pkg::ALIAS_CLR:   alias_apply = old & ~wd;
      tat_pkg::ALIAS_SET:   alias_apply = old | wd;
      tat_pkg::ALIAS_INV:   alias_apply = old ^ wd;
    endcase
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a[15:4] == off[15:4]);
  endfunction

  assign op = tat_pkg::tat_alias_type'(reg_addr[3:2]);

  // external inputs: three flops, change taken when stages two and three agree
  logic [2:0] pins;
  assign pins = {low_power_rc_clock, ext_clock_pin, secondary_oscillator};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          sync_q[gi] <= 3'h0;
          lvl_q[gi]  <= 1'b0;
        end else if (ce) begin
          sync_q[gi] <= {sync_q[gi][1:0], pins[gi]};
          if (sync_q[gi][1] == sync_q[gi][2]) begin
            lvl_q[gi] <= sync_q[gi][2];
          end
        end
      end
      assign rise[gi] = (sync_q[gi][1] == sync_q[gi][2]) && sync_q[gi][2]
                        && !lvl_q[gi];
    end
  endgenerate

  always_comb begin
    unique case (ctrl_q[tat_pkg::ECS_LSB +: 2])
      tat_pkg::ECS_SECONDARY_OSCILLATOR: ext_edge = rise[0];
      tat_pkg::ECS_PIN:  ext_edge = rise[1];
      tat_pkg::ECS_LOW_POWER_RC_CLOCK: ext_edge = rise[2];
      default:           ext_edge = 1'b0;
    endcase
  end

  // clock source and gating
  always_comb begin
    if (ctrl_q[tat_pkg::CS_BIT]) begin
      src_tick = ext_edge;
    end else if (ctrl_q[tat_pkg::GATE_BIT]) begin
      src_tick = lvl_q[1];
    end else begin
      src_tick = 1'b1;
    end
  end

  assign async_mode = ctrl_q[tat_pkg::CS_BIT]
                      && !ctrl_q[tat_pkg::SYNC_BIT];
  // synchronous modes stop in sleep, async keeps counting
  assign run = ctrl_q[tat_pkg::ON_BIT]
               && !(idle_mode && ctrl_q[tat_pkg::STOP_IN_IDLE_BIT])
               && !(sleep_mode && !async_mode);

  tat_prescaler #(.CNT_W(8)) u_pre (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .clear    (!ctrl_q[tat_pkg::ON_BIT]),
    .sel      (ctrl_q[tat_pkg::PS_LSB +: 2]),
    .tick_in  (run && src_tick),
    .tick_out (tick)
  );

  // control register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= tat_pkg::CTRL_RST;
    end else if (ce && reg_wr && hit(reg_addr, tat_pkg::CTRL_OFF)) begin
      ctrl_q <= alias_apply(ctrl_q, reg_wdata, op)
                & tat_pkg::CTRL_WMASK;
    end
  end

  // period register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      period_q <= CNT_W'(tat_pkg::PERIOD_RST);
    end else if (ce && reg_wr && hit(reg_addr, tat_pkg::PERIOD_OFF)) begin
      period_q <= CNT_W'(alias_apply(32'(period_q), reg_wdata, op));
    end
  end

  // count writes: async mode parks the value until the next source edge
  assign cnt_wr   = reg_wr && hit(reg_addr, tat_pkg::COUNT_OFF);
  assign cnt_take = cnt_wr && !(pend_q && ctrl_q[tat_pkg::WDIS_BIT]);
  assign cnt_base = pend_q ? pend_val_q : count_q;
  assign cnt_new  = CNT_W'(alias_apply(32'(cnt_base), reg_wdata, op));
  assign wrap     = tick && (count_q == period_q);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_q     <= 1'b0;
      pend_val_q <= '0;
    end else if (ce) begin
      if (cnt_take && async_mode) begin
        pend_q     <= 1'b1;
        pend_val_q <= cnt_new;
      end else if (pend_q && (ext_edge || !async_mode)) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_q <= CNT_W'(tat_pkg::COUNT_RST);
    end else if (ce) begin
      if (cnt_take && !async_mode) begin
        count_q <= cnt_new;
      end else if (pend_q && (ext_edge || !async_mode)) begin
        count_q <= pend_val_q;
      end else if (tick) begin
        count_q <= wrap ? '0 : count_q + CNT_W'(1);
      end
    end
  end

  // event outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_event              <= 1'b0;
      capacitive_sense_trigger <= 1'b0;
      wake_request             <= 1'b0;
    end else if (ce) begin
      timer_event              <= wrap;
      capacitive_sense_trigger <= wrap;
      wake_request             <= wrap && sleep_mode;
    end
  end

  // read data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (ce && reg_rd) begin
      if (hit(reg_addr, tat_pkg::CTRL_OFF)) begin
        reg_rdata <= (ctrl_q & tat_pkg::CTRL_RMASK)
                     | (32'(pend_q && async_mode) << tat_pkg::WIP_BIT);
      end else if (hit(reg_addr, tat_pkg::COUNT_OFF)) begin
        reg_rdata <= 32'(count_q);
      end else if (hit(reg_addr, tat_pkg::PERIOD_OFF)) begin
        reg_rdata <= 32'(period_q);
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_wrap_zero: assert property (
    ce && wrap && !cnt_take && !pend_q |=> count_q == '0 && timer_event)
    else $error("count did not wrap at period");
  a_count_step: assert property (
    ce && tick && !wrap && !cnt_take && !pend_q
    |=> count_q == $past(count_q) + CNT_W'(1))
    else $error("count did not step by one");
  a_off_freeze: assert property (
    !ctrl_q[tat_pkg::ON_BIT] && !cnt_wr && !pend_q |=> $stable(count_q))
    else $error("count moved while disabled");
  a_wdis_block: assert property (
    ce && pend_q && ctrl_q[tat_pkg::WDIS_BIT] && cnt_wr && !ext_edge
    |=> pend_q && $stable(pend_val_q))
    else $error("count write taken while pending");
  a_wip_read: assert property (
    ce && reg_rd && hit(reg_addr, tat_pkg::CTRL_OFF)
    |=> reg_rdata[tat_pkg::WIP_BIT] == $past(pend_q && async_mode))
    else $error("pending bit read wrong");
  a_ctrl_resv: assert property (
    ce && reg_rd |=> (reg_rdata & ~tat_pkg::CTRL_RMASK) == 32'h0
    || !$past(hit(reg_addr, tat_pkg::CTRL_OFF)))
    else $error("reserved control bits read nonzero");
  a_idle_stop: assert property (
    idle_mode && ctrl_q[tat_pkg::STOP_IN_IDLE_BIT] |-> !tick)
    else $error("tick while stopped in idle");
  a_ext_gate: assert property (
    ctrl_q[tat_pkg::CS_BIT] |-> src_tick == ext_edge)
    else $error("gate applied to external source");
  a_alias_set: assert property (
    ce && reg_wr && hit(reg_addr, tat_pkg::PERIOD_OFF)
    && op == tat_pkg::ALIAS_SET
    |=> period_q == ($past(period_q) | $past(CNT_W'(reg_wdata))))
    else $error("set alias wrong on period");
endmodule
`default_nettype wire

// [tb/tat_src_model.sv]
// external clock source model for the interval timer bench
`timescale 1ns/1ns
`default_nettype none
module tat_src_model (
  // clock
  input  wire logic       mclk,
  // run request per source
  input  wire logic [2:0] run,
  // source lines: oscillator, pin, rc clock
  output logic      [2:0] src
);
  logic [1:0] div_q;
  initial src = 3'h0;
  initial div_q = 2'h0;
  // a running line toggles every 4 clocks; a stopped line rests low
  always @(posedge mclk) begin
    div_q <= div_q + 2'h1;
    for (int i = 0; i < 3; i++) begin
      if (!run[i]) src[i] <= 1'b0;
      else if (div_q == 2'h3) src[i] <= ~src[i];
    end
  end
endmodule
`default_nettype wire

// [tb/type_a_interval_timer_test.sv]
// self-checking bench for the interval timer
`timescale 1ns/1ns
`default_nettype none
module type_a_interval_timer_test;
  logic        mclk, rst_n, ce, reg_wr, reg_rd, idle_mode, sleep_mode;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, a;
  logic [2:0]  run, src;
  logic        timer_event, capacitive_sense_trigger, wake_request;
  int          err_count, check_count, cyc, n, dv[4];
  tat_interval_timer uut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode),
    .secondary_oscillator(src[0]), .ext_clock_pin(src[1]),
    .low_power_rc_clock(src[2]), .timer_event(timer_event),
    .capacitive_sense_trigger(capacitive_sense_trigger),
    .wake_request(wake_request));
  tat_src_model model (.mclk(mclk), .run(run), .src(src));
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  task finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rng(input logic [31:0] g, input int lo, input int hi);
    check_count++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t got %h range %0d %0d", $time, g, lo, hi);
    end
  endtask
  task wr(input logic [15:0] ad, input logic [31:0] wd);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] ad, output logic [31:0] rv);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    #1 rv = reg_rdata;
  endtask
  task wait_ev;
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (timer_event !== 1'b1 && n < 50);
  endtask
  task ext_run(input logic [2:0] r);
    run <= r;
    repeat (80) @(posedge mclk);
    run <= 3'h0;
    repeat (8) @(posedge mclk);
  endtask
  initial begin
    rst_n = 1'b0; ce = 1'b1; reg_addr = 16'h0000; reg_wr = 1'b0;
    reg_rd = 1'b0; reg_wdata = 32'h0; idle_mode = 1'b0; sleep_mode = 1'b0;
    run = 3'h0; dv = '{1, 8, 64, 256};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(16'h2000, d); chk(d, 32'h0);
    rd(16'h2010, d); chk(d, 32'h0);
    rd(16'h2020, d); chk(d, 32'h0000FFFF);
    wr(16'h2000, 32'hFFFFFFFF);
    rd(16'h2000, d); chk(d, 32'h0000B3B6);
    wr(16'h2000, 32'h0);
    wr(16'h2024, 32'h0000F0F0);
    rd(16'h2020, d); chk(d, 32'h00000F0F);
    wr(16'h2028, 32'hF0000001);
    rd(16'h2020, d); chk(d, 32'hF0000F0F);
    wr(16'h202C, 32'hFFFFFFFF);
    rd(16'h2020, d); chk(d, 32'h0FFFF0F0);
    // wrap at period 2 gives an event every 3 ticks
    wr(16'h2020, 32'h2); wr(16'h2010, 32'h0); wr(16'h2008, 32'h8000);
    wait_ev; chk(capacitive_sense_trigger, 1'b1);
    wait_ev; chk(n, 3);
    wr(16'h2004, 32'h8000);
    rd(16'h2010, a); repeat (20) @(posedge mclk);
    rd(16'h2010, d); chk(d, a);
    wr(16'h2028, 32'hFFFFFFFF);
    for (int p = 0; p < 4; p++) begin
      wr(16'h2010, 32'h0); wr(16'h2000, 32'h8000 | (p << 4));
      repeat (768) @(posedge mclk);
      wr(16'h2004, 32'h8000); rd(16'h2010, d);
      rng(d, 768 / dv[p] - 2, 768 / dv[p] + 2);
    end
    wr(16'h2010, 32'h0); wr(16'h2000, 32'hA000); idle_mode <= 1'b1;
    repeat (50) @(posedge mclk);
    rd(16'h2010, d); chk(d, 32'h0);
    wr(16'h2004, 32'h2000); repeat (50) @(posedge mclk);
    rd(16'h2010, d); rng(d, 45, 62);
    idle_mode <= 1'b0;
    // gate first so the running count cannot step past the zero write
    wr(16'h2000, 32'h8080);
    wr(16'h2010, 32'h0);
    repeat (40) @(posedge mclk);
    rd(16'h2010, d); chk(d, 32'h0);
    ext_run(3'h2); rd(16'h2010, d); rng(d, 20, 60);
    for (int e = 0; e < 4; e++) begin
      wr(16'h2010, 32'h0); wr(16'h2000, 32'h8086 | (e << 8));
      ext_run(e == 3 ? 3'h7 : 3'h1 << e); rd(16'h2010, d);
      if (e == 3) chk(d, 32'h0);
      else rng(d, 8, 11);
    end
    wr(16'h2000, 32'h1002); wr(16'h2010, 32'h5);
    rd(16'h2000, d); chk(d, 32'h1802);
    wr(16'h2010, 32'h9);
    ext_run(3'h1); rd(16'h2010, d); chk(d, 32'h5);
    rd(16'h2000, d); chk(d, 32'h1002);
    wr(16'h2004, 32'h1000); wr(16'h2010, 32'h5);
    repeat (tat_pkg::COUNT_WR_SPACING) @(posedge mclk);
    wr(16'h2010, 32'h9);
    ext_run(3'h1); rd(16'h2010, d); chk(d, 32'h9);
    wr(16'h2000, 32'h6); wr(16'h2010, 32'h7);
    rd(16'h2000, d); chk(d, 32'h6);
    rd(16'h2010, d); chk(d, 32'h7);
    wr(16'h2020, 32'h1); wr(16'h2010, 32'h0); wr(16'h2000, 32'h8002);
    sleep_mode <= 1'b1; run <= 3'h1; n = 0;
    while (wake_request !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(wake_request, 1'b1);
    finish_test;
  end
endmodule
`default_nettype wire
